// file: hw/psm_consts.vh
// constants for the power and mode configuration registers
// assumes a 200 MHz mclk and a 16-bit management register port
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH
// clock and timing
// one ms of 5 ns cycles, sized to the divider counter
`define PSM_MS_CYCLES   18'd200000
`define PSM_MS_W        18
`define PSM_TMR_W       10
// pulse transmit intervals in ms
`define PSM_TX_INT_0_MS 10'd1000
`define PSM_TX_INT_1_MS 10'd768
`define PSM_TX_INT_2_MS 10'd512
`define PSM_TX_INT_3_MS 10'd256
// two-pulse wake gaps in ms
`define PSM_GAP_0_MS    10'd64
`define PSM_GAP_1_MS    10'd256
`define PSM_GAP_2_MS    10'd512
`define PSM_GAP_3_MS    10'd1000
// energy timeout and crossover extensions in ms
`define PSM_ENERGY_MS   10'd256
`define PSM_XO_SLEEP_MS 2976
`define PSM_XO_MAN_MS   1984
// register indices
`define PSM_IDX_PULSE   5'h10
`define PSM_IDX_MODE    5'h11
`define PSM_IDX_SPEC    5'h12
// pulse / crossover / low power idle register fields
`define PSM_TX_EN_BIT   15
`define PSM_TX_INT_HI   14
`define PSM_TX_INT_LO   13
`define PSM_WAKE1_BIT   12
`define PSM_GAP_HI      11
`define PSM_GAP_LO      10
`define PSM_LPI_BIT     2
`define PSM_XO_SLP_BIT  1
`define PSM_XO_MAN_BIT  0
`define PSM_PULSE_MASK  16'hFC07
`define PSM_PULSE_RST   16'h0001
// mode control register fields
`define PSM_PD_BIT      13
`define PSM_LOOP_BIT    9
`define PSM_ALT_BIT     6
`define PSM_ENERGY_BIT  1
`define PSM_MODE_MASK   16'h2241
`define PSM_MODE_RST    16'h0000
// special modes register fields
`define PSM_IFACE_BIT   14
`define PSM_OPM_HI      7
`define PSM_OPM_LO      5
`define PSM_ADDR_HI     4
`define PSM_ADDR_LO     0
// wake detector states
`define PSM_W_IDLE      2'b01
`define PSM_W_ARM       2'b10
`endif

// file: hw/psm_ms_div.v
// millisecond tick divider
// assumes one free-running mclk
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module psm_ms_div #(
  parameter [`PSM_MS_W-1:0] MS_CYCLES = `PSM_MS_CYCLES
) (
  input  wire                 mclk,
  input  wire                 resetn,
  output reg                  ms_tick
);
  reg [`PSM_MS_W-1:0] cnt;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt     <= {`PSM_MS_W{1'b0}};
      ms_tick <= 1'b0;
    end else if (cnt == MS_CYCLES - 1'b1) begin
      cnt     <= {`PSM_MS_W{1'b0}};
      ms_tick <= 1'b1;
    end else begin
      cnt     <= cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: hw/psm_ms_timer.v
// loadable millisecond countdown, done is a one-cycle pulse
// assumes ms_tick pulses once per millisecond; first ms may be short
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module psm_ms_timer (
  input  wire                  mclk,
  input  wire                  resetn,
  input  wire                  ms_tick,
  input  wire                  start,
  input  wire                  cancel,
  input  wire [`PSM_TMR_W-1:0] load_ms,
  output reg                   running,
  output reg                   done
);
  reg [`PSM_TMR_W-1:0] cnt;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt     <= {`PSM_TMR_W{1'b0}};
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cancel) begin
        running <= 1'b0;
      end else if (start) begin
        cnt     <= load_ms;
        running <= 1'b1;
      end else if (running && ms_tick) begin
        if (cnt == 10'h001) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
        cnt <= cnt - 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/psm_regs.v
// power-down, pulse, crossover and mode configuration registers
// assumes an external serial engine presents decoded index accesses
// and that straps are stable at reset release
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
//
// Operation
// - in sleep with transmit enable set, send single link pulses at interval
// - bits 14:13 select 1 s, 768 ms, 512 ms or 256 ms spacing
// - in sleep with single-pulse wake set, one received pulse wakes
// - otherwise two pulses within the gap of bits 11:10 wake
// - bit 2 enables low power idle operation, resets to zero
// - in sleep, bit 1 extends crossover time by 2976 ms
// - bit 0 extends forced-speed auto crossover by 1984 ms, resets one
// - mode bit 13 enables energy-detect power-down, resets zero
// - bit 9 loops received packets back, 100 Mb reduced interface only
// - remote loopback ignores the isolate control
// - bit 6 selects alternate interrupt scheme, zero primary
// - energy flag clears after 256 ms without energy, set with energy
// - hardware reset sets energy flag, software reset leaves it
// - read-only bit 14 reports interface type from strap
// - operating mode field 7:5 defaults from mode straps, writable
// - station address serves as bus address and scrambler seed
// - station address defaults from address strap, software may overwrite
// - registers reached by index, each index decoded to its register
module psm_regs #(
  parameter [`PSM_MS_W-1:0] MS_CYCLES = `PSM_MS_CYCLES
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        reduced_interface_strap,
  input  wire [2:0]  mode_strap,
  input  wire [4:0]  address_strap,
  input  wire        soft_reset,
  input  wire [4:0]  mgmt_index,
  input  wire        mgmt_wr,
  input  wire        mgmt_rd,
  input  wire [15:0] mgmt_wdata,
  output reg  [15:0] mgmt_rdata,
  output reg         mgmt_rvalid,
  input  wire        sleep_state,
  input  wire        link_pulse_rx,
  input  wire        line_energy,
  input  wire        auto_xover_en,
  input  wire        forced_speed,
  input  wire        speed_100,
  output wire        energy_powerdown_enable,
  output reg         link_test_pulse_tx,
  output reg         sleep_wake,
  output wire        low_power_idle_enable,
  output reg         xover_ext_sleep,
  output reg         xover_ext_manual,
  output reg         remote_loopback_enable,
  output wire        alternate_irq_select,
  output reg         host_interface_type,
  output reg         line_energy_present,
  output reg  [2:0]  op_mode,
  output reg  [4:0]  station_address
);
  reg  [15:0] pulse_cfg;
  reg  [15:0] mode_ctl;
  reg         straps_taken;
  reg  [1:0]  wstate;
  reg  [1:0]  next_wstate;
  reg         next_wake;
  reg         gap_start;
  reg         gap_cancel;
  reg  [9:0]  tx_load;
  reg  [9:0]  gap_load;
  reg  [15:0] next_rdata;
  wire        ms_tick;
  wire        tx_run;
  wire        tx_done;
  wire        gap_run;
  wire        gap_done;
  wire        en_run;
  wire        en_done;
  wire        wr_pulse;
  wire        wr_mode;
  wire        wr_spec;
  wire        asleep;
  wire        tx_active;
  wire        en_start;

  assign wr_pulse = mgmt_wr && (mgmt_index == `PSM_IDX_PULSE);
  assign wr_mode  = mgmt_wr && (mgmt_index == `PSM_IDX_MODE);
  assign wr_spec  = mgmt_wr && (mgmt_index == `PSM_IDX_SPEC);

  assign energy_powerdown_enable = mode_ctl[`PSM_PD_BIT];
  assign low_power_idle_enable   = pulse_cfg[`PSM_LPI_BIT];
  assign alternate_irq_select    = mode_ctl[`PSM_ALT_BIT];

  // sleep counts only when the power-down unit reports it and it is enabled
  assign asleep    = sleep_state && mode_ctl[`PSM_PD_BIT];
  assign tx_active = asleep && pulse_cfg[`PSM_TX_EN_BIT];

  // pulse configuration bits are not touched by software reset
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulse_cfg <= `PSM_PULSE_RST;
    end else if (wr_pulse) begin
      pulse_cfg <= mgmt_wdata & `PSM_PULSE_MASK;
    end
  end

  // mode control bits return to default on software reset
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_ctl <= `PSM_MODE_RST;
    end else if (soft_reset) begin
      mode_ctl <= `PSM_MODE_RST;
    end else if (wr_mode) begin
      mode_ctl <= mgmt_wdata & `PSM_MODE_MASK;
    end
  end

  // straps caught on the first edge after release, never under reset
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      straps_taken        <= 1'b0;
      host_interface_type <= 1'b0;
      op_mode             <= 3'h0;
      station_address     <= 5'h00;
    end else if (!straps_taken) begin
      straps_taken        <= 1'b1;
      host_interface_type <= reduced_interface_strap;
      op_mode             <= mode_strap;
      station_address     <= address_strap;
    end else if (wr_spec) begin
      op_mode         <= mgmt_wdata[`PSM_OPM_HI:`PSM_OPM_LO];
      station_address <= mgmt_wdata[`PSM_ADDR_HI:`PSM_ADDR_LO];
    end
  end

  psm_ms_div #(
    .MS_CYCLES (MS_CYCLES)
  ) u_div (
    .mclk    (mclk),
    .resetn  (resetn),
    .ms_tick (ms_tick)
  );

  always @* begin
    case (pulse_cfg[`PSM_TX_INT_HI:`PSM_TX_INT_LO])
      2'b00:   tx_load = `PSM_TX_INT_0_MS;
      2'b01:   tx_load = `PSM_TX_INT_1_MS;
      2'b10:   tx_load = `PSM_TX_INT_2_MS;
      default: tx_load = `PSM_TX_INT_3_MS;
    endcase
    case (pulse_cfg[`PSM_GAP_HI:`PSM_GAP_LO])
      2'b00:   gap_load = `PSM_GAP_0_MS;
      2'b01:   gap_load = `PSM_GAP_1_MS;
      2'b10:   gap_load = `PSM_GAP_2_MS;
      default: gap_load = `PSM_GAP_3_MS;
    endcase
  end

  // transmit timer reloads itself one cycle after each expiry
  psm_ms_timer u_tx (
    .mclk    (mclk),
    .resetn  (resetn),
    .ms_tick (ms_tick),
    .start   (tx_active && !tx_run),
    .cancel  (!tx_active),
    .load_ms (tx_load),
    .running (tx_run),
    .done    (tx_done)
  );

  psm_ms_timer u_gap (
    .mclk    (mclk),
    .resetn  (resetn),
    .ms_tick (ms_tick),
    .start   (gap_start),
    .cancel  (gap_cancel),
    .load_ms (gap_load),
    .running (gap_run),
    .done    (gap_done)
  );

  // energy present restarts the timeout; after a timeout it stays idle
  assign en_start = line_energy || (!en_run && line_energy_present && !en_done);

  psm_ms_timer u_energy (
    .mclk    (mclk),
    .resetn  (resetn),
    .ms_tick (ms_tick),
    .start   (en_start),
    .cancel  (1'b0),
    .load_ms (`PSM_ENERGY_MS),
    .running (en_run),
    .done    (en_done)
  );

  // wake detection: single pulse, or a second pulse inside the gap
  always @* begin
    next_wstate = wstate;
    next_wake   = 1'b0;
    gap_start   = 1'b0;
    gap_cancel  = 1'b0;
    if (!asleep) begin
      next_wstate = `PSM_W_IDLE;
      gap_cancel  = 1'b1;
    end else if (pulse_cfg[`PSM_WAKE1_BIT]) begin
      next_wstate = `PSM_W_IDLE;
      gap_cancel  = 1'b1;
      next_wake   = link_pulse_rx;
    end else begin
      case (wstate)
        `PSM_W_IDLE: begin
          if (link_pulse_rx) begin
            next_wstate = `PSM_W_ARM;
            gap_start   = 1'b1;
          end
        end
        `PSM_W_ARM: begin
          if (link_pulse_rx && gap_run) begin
            next_wake   = 1'b1;
            next_wstate = `PSM_W_IDLE;
            gap_cancel  = 1'b1;
          end else if (link_pulse_rx) begin
            gap_start = 1'b1;
          end else if (!gap_run) begin
            next_wstate = `PSM_W_IDLE;
          end
        end
        default: begin
          next_wstate = `PSM_W_IDLE;
          gap_cancel  = 1'b1;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wstate     <= `PSM_W_IDLE;
      sleep_wake <= 1'b0;
    end else begin
      wstate     <= next_wstate;
      sleep_wake <= next_wake;
    end
  end

  // gated control outputs, registered so every output is a flop
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link_test_pulse_tx     <= 1'b0;
      xover_ext_sleep        <= 1'b0;
      xover_ext_manual       <= 1'b0;
      remote_loopback_enable <= 1'b0;
    end else begin
      link_test_pulse_tx <= tx_done && tx_active;
      xover_ext_sleep    <= asleep && pulse_cfg[`PSM_XO_SLP_BIT];
      xover_ext_manual   <= auto_xover_en && forced_speed &&
                            pulse_cfg[`PSM_XO_MAN_BIT];
      // isolate is deliberately not an input here
      remote_loopback_enable <= mode_ctl[`PSM_LOOP_BIT] &&
                                host_interface_type && speed_100;
    end
  end

  // energy flag keeps its value through software reset
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      line_energy_present <= 1'b1;
    end else if (line_energy) begin
      line_energy_present <= 1'b1;
    end else if (en_done) begin
      line_energy_present <= 1'b0;
    end
  end

  always @* begin
    next_rdata = 16'h0000;
    case (mgmt_index)
      `PSM_IDX_PULSE: begin
        next_rdata = pulse_cfg;
      end
      `PSM_IDX_MODE: begin
        next_rdata = mode_ctl;
        next_rdata[`PSM_ENERGY_BIT] = line_energy_present;
      end
      `PSM_IDX_SPEC: begin
        next_rdata[`PSM_IFACE_BIT] = host_interface_type;
        next_rdata[`PSM_OPM_HI:`PSM_OPM_LO] = op_mode;
        next_rdata[`PSM_ADDR_HI:`PSM_ADDR_LO] = station_address;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/phy_power_mode_config_regs_tb.sv
// self-checking bench for the power and mode register block
// assumes psm_sta_model drives the register port; mclk 200 MHz
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module phy_power_mode_config_regs_tb;
  // 20 cycles per ms keeps second-long intervals short
  localparam int MS = 20;
  logic mclk, resetn, soft_reset, sleep_state, link_pulse_rx, line_energy;
  logic auto_xover_en, forced_speed, speed_100;
  wire [4:0] mgmt_index, station_address;
  wire [15:0] mgmt_wdata, mgmt_rdata;
  wire [2:0] op_mode;
  wire mgmt_wr, mgmt_rd, mgmt_rvalid, energy_powerdown_enable, link_test_pulse_tx, sleep_wake;
  wire low_power_idle_enable, xover_ext_sleep, xover_ext_manual, remote_loopback_enable;
  wire alternate_irq_select, host_interface_type, line_energy_present;
  int fails = 0;
  int num_checks = 0;
  psm_sta_model sta (.mclk, .mgmt_rdata, .mgmt_rvalid, .mgmt_index, .mgmt_wr, .mgmt_rd,
    .mgmt_wdata);
  psm_regs #(.MS_CYCLES(`PSM_MS_W'(MS))) DUT (.mclk, .resetn, .reduced_interface_strap(1'b1),
    .mode_strap(3'b101), .address_strap(5'h0A), .soft_reset, .mgmt_index, .mgmt_wr, .mgmt_rd,
    .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .sleep_state, .link_pulse_rx, .line_energy,
    .auto_xover_en, .forced_speed, .speed_100, .energy_powerdown_enable, .link_test_pulse_tx,
    .sleep_wake, .low_power_idle_enable, .xover_ext_sleep, .xover_ext_manual,
    .remote_loopback_enable, .alternate_irq_select, .host_interface_type,
    .line_energy_present, .op_mode, .station_address);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    sta.rd(idx, d);
    chk(d, exp);
  endtask
  task automatic pulse(output logic w);
    @(negedge mclk);
    link_pulse_rx = 1'b1;
    @(negedge mclk);
    link_pulse_rx = 1'b0;
    w = sleep_wake;
  endtask
  task automatic t_regs();
    rdchk(5'h10, 16'h0001);
    rdchk(5'h11, 16'h0002);
    rdchk(5'h12, 16'h40AA);
    chk({8'h00, op_mode, station_address}, 16'h00AA);
    sta.wr(5'h10, 16'hFFFF);
    rdchk(5'h10, 16'hFC07);
    sta.wr(5'h11, 16'hFFFF);
    rdchk(5'h11, 16'h2243);
    sta.wr(5'h12, 16'h0000);
    rdchk(5'h12, 16'h4000);
    sta.wr(5'h13, 16'hFFFF);
    rdchk(5'h13, 16'h0000);
    chk({low_power_idle_enable, alternate_irq_select, energy_powerdown_enable}, 3'h7);
    line_energy = 1'b1;
  endtask
  task automatic t_loop_xo();
    sta.wr(5'h10, 16'h0003);
    sta.wr(5'h11, 16'h2240);
    {speed_100, auto_xover_en, forced_speed, sleep_state} = 4'hF;
    repeat (2) @(negedge mclk);
    chk({remote_loopback_enable, xover_ext_manual, xover_ext_sleep}, 3'h7);
    {speed_100, auto_xover_en, sleep_state} = 3'h0;
    repeat (2) @(negedge mclk);
    chk({remote_loopback_enable, xover_ext_manual, xover_ext_sleep}, 3'h0);
  endtask
  task automatic t_wake();
    logic w;
    sta.wr(5'h10, 16'h1001);
    sleep_state = 1'b1;
    pulse(w);
    chk(w, 1'b1);
    sta.wr(5'h10, 16'h0001);
    pulse(w);
    chk(w, 1'b0);
    repeat (30 * MS) @(negedge mclk);
    pulse(w);
    chk(w, 1'b1);
    repeat (70 * MS) @(negedge mclk);
    pulse(w);
    repeat (70 * MS) @(negedge mclk);
    pulse(w);
    chk(w, 1'b0);
    sta.wr(5'h10, 16'h0401);
    repeat (70 * MS) @(negedge mclk);
    pulse(w);
    repeat (200 * MS) @(negedge mclk);
    pulse(w);
    chk(w, 1'b1);
    sleep_state = 1'b0;
  endtask
  task automatic t_tx();
    int n;
    int ms[4] = '{1000, 768, 512, 256};
    for (int c = 0; c < 4; c++) begin
      sta.wr(5'h10, {1'b1, c[1:0], 13'h0001});
      sleep_state = 1'b1;
      n = 0;
      while (link_test_pulse_tx !== 1'b1 && n < 25000) begin
        @(negedge mclk);
        n++;
      end
      chk(n >= (ms[c] - 1) * MS && n <= ms[c] * MS + 3, 1'b1);
      sleep_state = 1'b0;
    end
    sta.wr(5'h10, 16'h6001);
    sleep_state = 1'b1;
    n = 0;
    repeat (300 * MS) begin
      @(negedge mclk);
      n += link_test_pulse_tx;
    end
    chk(n, 16'h0);
    sleep_state = 1'b0;
  endtask
  task automatic t_energy();
    @(negedge mclk);
    line_energy = 1'b0;
    repeat (250 * MS) @(negedge mclk);
    rdchk(5'h11, 16'h2242);
    repeat (8 * MS) @(negedge mclk);
    chk(line_energy_present, 1'b0);
    soft_reset = 1'b1;
    @(negedge mclk);
    soft_reset = 1'b0;
    rdchk(5'h11, 16'h0000);
    line_energy = 1'b1;
    @(negedge mclk);
    chk(line_energy_present, 1'b1);
  endtask
  // mid-run hardware reset with the flag low: flag returns to one, straps reload
  task automatic t_hw_reset();
    line_energy = 1'b0;
    repeat (258 * MS) @(negedge mclk);
    chk(line_energy_present, 1'b0);
    resetn = 1'b0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    rdchk(5'h11, 16'h0002);
    chk({host_interface_type, op_mode, station_address}, 16'h01AA);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {resetn, soft_reset, sleep_state, link_pulse_rx, line_energy} = 5'h0;
    {auto_xover_en, forced_speed, speed_100} = 3'h0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    t_regs();
    t_loop_xo();
    t_wake();
    t_tx();
    t_energy();
    t_hw_reset();
    give_verdict();
  end
  // the run needs about 76k cycles; 90k means a hang
  initial begin
    #450000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire

// file: testbench/psm_regs_props.sv
// assertions on the ports of the power and mode register block
// assumes one mclk domain with async active-low resetn
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module psm_regs_props #(
  parameter [`PSM_MS_W-1:0] MS_CYCLES = `PSM_MS_CYCLES
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [4:0] address_strap,
  input wire logic       mgmt_rd,
  input wire logic       mgmt_rvalid,
  input wire logic       sleep_state,
  input wire logic       link_pulse_rx,
  input wire logic       line_energy,
  input wire logic       auto_xover_en,
  input wire logic       forced_speed,
  input wire logic       speed_100,
  input wire logic       energy_powerdown_enable,
  input wire logic       link_test_pulse_tx,
  input wire logic       sleep_wake,
  input wire logic       xover_ext_sleep,
  input wire logic       xover_ext_manual,
  input wire logic       remote_loopback_enable,
  input wire logic       host_interface_type,
  input wire logic       line_energy_present,
  input wire logic [4:0] station_address
);
  // ms ticks are not aligned to the falling edge, so allow two ms early
  localparam int LO = 254 * MS_CYCLES;
  localparam int HI = 257 * MS_CYCLES;
  logic [31:0] low_cnt;
  wire         asleep = sleep_state & energy_powerdown_enable;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      low_cnt <= 32'h0;
    else if (line_energy)
      low_cnt <= 32'h0;
    // saturate high enough for the full-rate millisecond as well
    else if (low_cnt < 32'hFFFF_FFFF)
      low_cnt <= low_cnt + 32'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  rd_answer_a: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read strobe not answered");
  rv_single_a: assert property (!mgmt_rd |=> !mgmt_rvalid)
    else $error("read valid without a read");
  tx_gated_a: assert property (!asleep [*3] |=> !link_test_pulse_tx)
    else $error("link pulse sent while awake");
  wake_cause_a: assert property (sleep_wake |-> $past(link_pulse_rx & sleep_state))
    else $error("wake without a received pulse");
  xs_gate_a: assert property (!asleep |=> !xover_ext_sleep)
    else $error("sleep crossover extension while awake");
  xm_gate_a: assert property (!(auto_xover_en & forced_speed) |=> !xover_ext_manual)
    else $error("manual crossover extension without forced speed");
  loop_gate_a: assert property (!(host_interface_type & speed_100) |=> !remote_loopback_enable)
    else $error("loopback outside reduced interface at 100");
  energy_on_a: assert property (line_energy |=> line_energy_present)
    else $error("energy flag not set by energy");
  energy_late_a: assert property ($fell(line_energy_present) |-> low_cnt >= LO)
    else $error("energy flag fell too early");
  energy_drop_a: assert property (low_cnt > HI |-> !line_energy_present)
    else $error("energy flag did not fall");
  addr_strap_a: assert property ($rose(resetn) |=> station_address == $past(address_strap))
    else $error("station address not loaded from strap");
  cover property (sleep_wake);
  cover property (link_test_pulse_tx);
  cover property ($fell(line_energy_present));
endmodule
bind psm_regs psm_regs_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .mclk, .resetn, .address_strap, .mgmt_rd, .mgmt_rvalid, .sleep_state, .link_pulse_rx,
  .line_energy, .auto_xover_en, .forced_speed, .speed_100, .energy_powerdown_enable,
  .link_test_pulse_tx, .sleep_wake, .xover_ext_sleep, .xover_ext_manual,
  .remote_loopback_enable, .host_interface_type, .line_energy_present, .station_address
);
`default_nettype wire

// file: testbench/psm_sta_model.sv
// station management model: indexed register reads and writes
// assumes reads are answered by mgmt_rvalid within a few cycles
`timescale 1ns/1ps
`default_nettype none
module psm_sta_model (
  input  wire logic        mclk,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid,
  output var  logic [4:0]  mgmt_index,
  output var  logic        mgmt_wr,
  output var  logic        mgmt_rd,
  output var  logic [15:0] mgmt_wdata
);
  initial begin
    {mgmt_index, mgmt_wr, mgmt_rd, mgmt_wdata} = 23'h0;
  end
  // strobes move on falling edges, away from the sampling edge
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(negedge mclk);
    mgmt_index = idx;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge mclk);
    mgmt_wr = 1'b0;
    mgmt_wdata = ~d; // released data must not keep its last value
  endtask
  task automatic rd(input logic [4:0] idx, output logic [15:0] d);
    int n;
    @(negedge mclk);
    mgmt_index = idx;
    mgmt_rd = 1'b1;
    @(negedge mclk);
    mgmt_rd = 1'b0;
    n = 0;
    while (mgmt_rvalid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire
